// ### src/cbp_ctrl.v
`timescale 1ns/1ps
// Function
// - Boost allowed only above low-battery threshold and bus below battery plus offset
// - Boost requested only with on-the-go pin high and charge field 10
// - Boost starts 220 ms after request with all conditions holding
// - Input source status reads 11 while boosting
// - One bit selects boost current limit 500 mA or 1.3 A
// - Boost fault sets sticky fault bit and raises interrupt
// - Three-bit minimum system voltage field resets to 3.5 V code
// - Minimum-system-regulation status high while rail held at minimum
// - Input overload when current over limit or voltage under limit; reduce charge
// - Dynamic power status high while either limiting loop is active
// - Battery switch on when rail below battery, off below depletion
// - Charge configuration field resets to 01 for autonomous charging
// - Default charge parameters 4.208 V, 2.048 A, 256 mA, 8 hours
// - New cycle needs converter up, field 01, enable pin low, no faults
// - Terminate when current below threshold and battery above recharge, with neither limiting loop active
// - After termination restart when battery falls below recharge threshold
// - Status pin low charging, high done or disabled, blinking on fault
// - Phase field 00 disabled, 01 precharge, 10 fast, 11 done
// - Interrupt pulse each time a charging cycle completes
// - Each interrupt is one low pulse of 256 us; one event queues behind a running pulse, further ones are dropped
// - Status pin blinks at 1 Hz in fault suspend
// - Battery switch disable bit forces switch off until cleared
`include "cbp_map.vh"
module cbp_ctrl #(
  parameter BOOST_DLY_CYC = `CBP_BOOST_DLY_CYC,
  parameter INT_CYC = `CBP_INT_CYC,
  parameter BLINK_HALF_CYC = `CBP_BLINK_HALF_CYC,
  parameter [2:0] MINSYS_RESET = `CBP_MINSYS_RESET
) (
  input wire sys_clk_i,
  input wire rst_i,
  // Pins, asynchronous to the clock
  input wire otg_pin_i,
  input wire charge_en_n_i,
  // Comparator results from the analog side, asynchronous
  input wire bat_above_low_i,
  input wire bus_below_bat_sleep_i,
  input wire boost_fault_i,
  input wire converter_up_i,
  input wire thermistor_fault_i,
  input wire timer_fault_i,
  input wire sys_at_min_i,
  input wire in_cur_over_i,
  input wire in_volt_under_i,
  input wire sys_below_bat_i,
  input wire bat_below_depl_i,
  input wire ichg_below_term_i,
  input wire bat_above_rechg_i,
  input wire bat_above_precharge_i,
  // Configuration written by the host side
  input wire [1:0] charge_config_i,
  input wire charge_config_we_i,
  input wire boost_ilim_sel_i,
  input wire boost_ilim_we_i,
  input wire [2:0] min_sys_i,
  input wire min_sys_we_i,
  input wire batlow_sel_i,
  input wire rechg_sel_i,
  input wire cfg_bits_we_i,
  input wire switch_disable_i,
  input wire switch_disable_we_i,
  input wire fault_read_i,
  // Configuration and status to host
  output wire [1:0] charge_config_o,
  output wire boost_ilim_sel_o,
  output wire [2:0] min_sys_o,
  output wire batlow_sel_o,
  output wire rechg_sel_o,
  output wire switch_disable_o,
  output wire [1:0] input_source_status_o,
  output wire [1:0] charge_phase_o,
  output wire dpm_status_o,
  output wire min_sys_status_o,
  output wire boost_fault_bit_o,
  // Analog controls
  output wire boost_on_o,
  output wire boost_ilim_high_o,
  output wire reduce_charge_o,
  output wire battery_path_switch_o,
  output wire charging_o,
  // Status pin, open drain
  output wire stat_pin_o,
  output wire stat_pin_oe_o,
  output wire int_n_o
);
  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  localparam NS = 16;
  wire [NS-1:0] raw_in;
  reg [NS-1:0] sync1;
  reg [NS-1:0] sync2;
  assign raw_in = {otg_pin_i, charge_en_n_i, bat_above_low_i, bus_below_bat_sleep_i,
    boost_fault_i, converter_up_i, thermistor_fault_i, timer_fault_i, sys_at_min_i,
    in_cur_over_i, in_volt_under_i, sys_below_bat_i, bat_below_depl_i,
    ichg_below_term_i, bat_above_rechg_i, bat_above_precharge_i};

  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sync1 <= {NS{1'b0}};
      sync2 <= {NS{1'b0}};
    end else begin
      sync1 <= raw_in;
      sync2 <= sync1;
    end
  end

  wire otg_s = sync2[15];
  wire ce_n_s = sync2[14];
  wire bat_low_ok_s = sync2[13];
  wire bus_low_s = sync2[12];
  wire bfault_s = sync2[11];
  wire conv_up_s = sync2[10];
  wire ts_fault_s = sync2[9];
  wire tmr_fault_s = sync2[8];
  wire sys_min_s = sync2[7];
  wire icur_s = sync2[6];
  wire vund_s = sync2[5];
  wire sys_low_s = sync2[4];
  wire depl_s = sync2[3];
  wire term_i_s = sync2[2];
  wire above_rechg_s = sync2[1];
  wire above_pre_s = sync2[0];

  // ----------------------------------------
  // Configuration fields
  // ----------------------------------------
  reg [1:0] chg_cfg;
  reg ilim_sel;
  reg [2:0] min_sys;
  reg batlow_sel;
  reg rechg_sel;
  reg sw_dis;

  // Host writes take effect at once, whatever the block is doing
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      chg_cfg <= `CBP_CHG_RESET;
      ilim_sel <= 1'b0;
      min_sys <= MINSYS_RESET;
      batlow_sel <= 1'b1;
      rechg_sel <= 1'b0;
      sw_dis <= 1'b0;
    end else begin
      if (charge_config_we_i)
        chg_cfg <= charge_config_i;
      if (boost_ilim_we_i)
        ilim_sel <= boost_ilim_sel_i;
      if (min_sys_we_i)
        min_sys <= min_sys_i;
      if (cfg_bits_we_i) begin
        batlow_sel <= batlow_sel_i;
        rechg_sel <= rechg_sel_i;
      end
      if (switch_disable_we_i)
        sw_dis <= switch_disable_i;
    end
  end

  // ----------------------------------------
  // Boost mode
  // ----------------------------------------
  // boost request
  wire boost_req = otg_s && (chg_cfg == `CBP_CHG_BOOST);
  wire boost_ok = boost_req && bat_low_ok_s && bus_low_s;
  reg [31:0] boost_cnt;
  reg boost_on;

  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      boost_cnt <= 32'h0000_0000;
      boost_on <= 1'b0;
    end else if (!boost_ok) begin
      boost_cnt <= 32'h0000_0000;
      boost_on <= 1'b0;
    end else if (!boost_on) begin
      if (boost_cnt == BOOST_DLY_CYC - 1)
        boost_on <= 1'b1;
      else
        boost_cnt <= boost_cnt + 32'h0000_0001;
    end
  end

  // sticky boost fault, set wins over read clear
  reg bfault_bit;
  reg bfault_prev;
  wire bfault_evt = boost_on && bfault_s && !bfault_prev;
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      bfault_bit <= 1'b0;
      bfault_prev <= 1'b0;
    end else begin
      bfault_prev <= boost_on && bfault_s;
      if (bfault_evt)
        bfault_bit <= 1'b1;
      else if (fault_read_i)
        bfault_bit <= 1'b0;
    end
  end

  // ----------------------------------------
  // Power path
  // ----------------------------------------
  localparam ST_IDLE = 2'd0;
  localparam ST_CHG = 2'd1;
  localparam ST_DONE = 2'd2;
  localparam ST_SUSP = 2'd3;
  reg [1:0] state;
  wire charging = (state == ST_CHG);
  reg path_sw;
  reg dynamic_power_limiting;
  reg minsys_st;

  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      path_sw <= 1'b0;
      dynamic_power_limiting <= 1'b0;
      minsys_st <= 1'b0;
    end else begin
      dynamic_power_limiting <= icur_s || vund_s;
      minsys_st <= sys_min_s;
      if (sw_dis || depl_s)
        path_sw <= 1'b0;
      else if (sys_low_s || charging)
        path_sw <= 1'b1;
      else
        path_sw <= 1'b0;
    end
  end

  // ----------------------------------------
  // Charge cycle sequencer
  // ----------------------------------------
  reg [1:0] next_state;
  reg done_evt;
  wire chg_enabled = (chg_cfg == `CBP_CHG_CHARGE) && !ce_n_s && !sw_dis && conv_up_s;
  wire chg_fault = ts_fault_s || tmr_fault_s;

  always @* begin
    next_state = state;
    done_evt = 1'b0;
    case (state)
      ST_IDLE: begin
        if (chg_enabled && chg_fault)
          next_state = ST_SUSP;
        else if (chg_enabled)
          next_state = ST_CHG;
      end
      ST_CHG: begin
        if (!chg_enabled)
          next_state = ST_IDLE;
        else if (chg_fault)
          next_state = ST_SUSP;
        else if (term_i_s && above_rechg_s && !dynamic_power_limiting) begin
          next_state = ST_DONE;
          done_evt = 1'b1;
        end
      end
      ST_DONE: begin
        if (!chg_enabled)
          next_state = ST_IDLE;
        else if (!above_rechg_s)
          next_state = ST_CHG;
      end
      ST_SUSP: begin
        if (!chg_enabled)
          next_state = ST_IDLE;
        else if (!chg_fault)
          next_state = ST_CHG;
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i)
      state <= ST_IDLE;
    else
      state <= next_state;
  end

  reg [1:0] phase;
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i)
      phase <= `CBP_PH_DISABLED;
    else if (next_state == ST_CHG)
      phase <= above_pre_s ? `CBP_PH_FAST : `CBP_PH_PRE;
    else if (next_state == ST_DONE)
      phase <= `CBP_PH_DONE;
    else
      phase <= `CBP_PH_DISABLED;
  end

  // ----------------------------------------
  // Status pin
  // ----------------------------------------
  reg [31:0] blink_cnt;
  reg blink;
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      blink_cnt <= 32'h0000_0000;
      blink <= 1'b0;
    end else if (state != ST_SUSP) begin
      blink_cnt <= 32'h0000_0000;
      blink <= 1'b0;
    end else if (blink_cnt == BLINK_HALF_CYC - 1) begin
      blink_cnt <= 32'h0000_0000;
      blink <= ~blink;
    end else begin
      blink_cnt <= blink_cnt + 32'h0000_0001;
    end
  end

  // status pin drive; released means high
  reg stat_oe;
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i)
      stat_oe <= 1'b0;
    else
      stat_oe <= (state == ST_CHG) || ((state == ST_SUSP) && blink);
  end

  // ----------------------------------------
  // Interrupt
  // ----------------------------------------
  // completion or boost fault event
  wire int_evt = done_evt || bfault_evt;
  cbp_pulse #(
    .WIDTH(32),
    .LEN(INT_CYC)
  ) u_int (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .trig_i(int_evt),
    .pulse_n_o(int_n_o),
    .busy_o()
  );

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign charge_config_o = chg_cfg;
  assign boost_ilim_sel_o = ilim_sel;
  assign min_sys_o = min_sys;
  assign batlow_sel_o = batlow_sel;
  assign rechg_sel_o = rechg_sel;
  assign switch_disable_o = sw_dis;
  assign input_source_status_o = boost_on ? `CBP_SRC_BOOST : 2'b00;
  assign charge_phase_o = phase;
  assign dpm_status_o = dynamic_power_limiting;
  assign min_sys_status_o = minsys_st;
  assign boost_fault_bit_o = bfault_bit;
  assign boost_on_o = boost_on;
  assign boost_ilim_high_o = ilim_sel;
  assign reduce_charge_o = dynamic_power_limiting;
  assign battery_path_switch_o = path_sw;
  assign charging_o = charging;
  assign stat_pin_o = 1'b0;
  assign stat_pin_oe_o = stat_oe;
  // defaults held by the analog trim: 4.208 V, 2.048 A, 256 mA, 8 h
endmodule

// ### src/cbp_map.vh
`ifndef CBP_MAP_VH
`define CBP_MAP_VH

// Charge configuration field encodings
`define CBP_CHG_DISABLE 2'b00
`define CBP_CHG_CHARGE 2'b01
`define CBP_CHG_BOOST 2'b10
`define CBP_CHG_RESET 2'b01

// Input source status encodings
`define CBP_SRC_BOOST 2'b11

// Charge phase encodings
`define CBP_PH_DISABLED 2'b00
`define CBP_PH_PRE 2'b01
`define CBP_PH_FAST 2'b10
`define CBP_PH_DONE 2'b11

// Reset values of configuration fields
`define CBP_MINSYS_RESET 3'h5
`define CBP_MINSYS_MV 3500
`define CBP_VREG_RESET_MV 4208
`define CBP_ICHG_RESET_MA 2048
`define CBP_IPRE_RESET_MA 256
`define CBP_ITERM_RESET_MA 256
`define CBP_TIMER_RESET_H 8
`define CBP_ILIM_LOW_MA 500
`define CBP_ILIM_HIGH_MA 1300

// Timing
`define CBP_CLK_MHZ 250
`define CBP_BOOST_DLY_MS 220
`define CBP_BOOST_DLY_CYC (`CBP_BOOST_DLY_MS * 1000 * `CBP_CLK_MHZ)
`define CBP_INT_US 256
`define CBP_INT_CYC (`CBP_INT_US * `CBP_CLK_MHZ)
`define CBP_BLINK_HZ 1
`define CBP_BLINK_HALF_CYC (`CBP_CLK_MHZ * 1000000 / (2 * `CBP_BLINK_HZ))

`endif

// ### src/cbp_pulse.v
`timescale 1ns/1ps
// ----------------------------------------
// Fixed-width low-going pulse generator
// ----------------------------------------
module cbp_pulse #(
  parameter WIDTH = 16,
  parameter [WIDTH-1:0] LEN = 16'h0010
) (
  input wire sys_clk_i,
  input wire rst_i,
  input wire trig_i,
  output wire pulse_n_o,
  output wire busy_o
);
  reg [WIDTH-1:0] count;
  reg pulse_n;
  reg pend;

  // Events during a running pulse are queued once; further ones in that pulse are dropped
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      count <= {WIDTH{1'b0}};
      pulse_n <= 1'b1;
      pend <= 1'b0;
    end else if (!pulse_n) begin
      if (trig_i)
        pend <= 1'b1;
      if (count == LEN - 1'b1) begin
        pulse_n <= 1'b1;
        count <= {WIDTH{1'b0}};
      end else begin
        count <= count + 1'b1;
      end
    end else if (trig_i || pend) begin
      pulse_n <= 1'b0;
      pend <= 1'b0;
      count <= {WIDTH{1'b0}};
    end
  end

  assign pulse_n_o = pulse_n;
  assign busy_o = ~pulse_n;
endmodule

// ### verif/cbp_ctrl_monitor.sv
`timescale 1ns/1ps
// ------------------
// Port checker
// ------------------
module cbp_ctrl_monitor #(
  parameter BOOST_DLY_CYC = 20,
  parameter INT_CYC = 16
) (
  input wire sys_clk_i,
  input wire rst_i,
  input wire otg_pin_i,
  input wire bat_above_low_i,
  input wire bus_below_bat_sleep_i,
  input wire in_cur_over_i,
  input wire in_volt_under_i,
  input wire fault_read_i,
  input wire [1:0] charge_config_o,
  input wire switch_disable_o,
  input wire [1:0] input_source_status_o,
  input wire [1:0] charge_phase_o,
  input wire dpm_status_o,
  input wire boost_fault_bit_o,
  input wire boost_on_o,
  input wire reduce_charge_o,
  input wire battery_path_switch_o,
  input wire charging_o,
  input wire stat_pin_o,
  input wire stat_pin_oe_o,
  input wire int_n_o
);
  wire go = otg_pin_i && bat_above_low_i && bus_below_bat_sleep_i && charge_config_o == 2'h2;
  reg [31:0] held;
  reg [31:0] low;
  // Wide counters so the full-length delays never wrap
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      held <= 32'h0000_0000;
      low <= 32'h0000_0000;
    end else begin
      held <= go ? held + 32'h0000_0001 : 32'h0000_0000;
      low <= int_n_o ? 32'h0000_0000 : low + 32'h0000_0001;
    end
  end
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);
  boost_src_a: assert property (boost_on_o |-> input_source_status_o == 2'h3)
    else $error("source status not boost");
  boost_gate_a: assert property ($rose(boost_on_o) |-> go)
    else $error("boost without its conditions");
  boost_wait_a: assert property ($rose(boost_on_o) |-> held >= BOOST_DLY_CYC)
    else $error("boost started early");
  fault_hold_a: assert property ($fell(boost_fault_bit_o) |-> $past(fault_read_i))
    else $error("fault bit cleared without read");
  dpm_flag_a: assert property ((in_cur_over_i || in_volt_under_i) [*5] |->
    dpm_status_o && reduce_charge_o) else $error("limiting not flagged");
  done_int_a: assert property ($rose(charge_phase_o == 2'h3) |-> ##[0:40] !int_n_o)
    else $error("no interrupt on completion");
  int_width_a: assert property ($rose(int_n_o) |-> low == INT_CYC)
    else $error("interrupt pulse width wrong");
  stat_low_a: assert property (charging_o && $past(charging_o) |->
    stat_pin_oe_o && !stat_pin_o) else $error("status pin not low while charging");
  switch_off_a: assert property (switch_disable_o && $past(switch_disable_o) |->
    !battery_path_switch_o) else $error("switch on while disabled");
  cover property ($rose(boost_on_o));
  cover property ($rose(int_n_o));
  cover property (charge_phase_o == 2'h3);
endmodule
bind cbp_ctrl cbp_ctrl_monitor #(.BOOST_DLY_CYC(BOOST_DLY_CYC), .INT_CYC(INT_CYC)) mon (
  .sys_clk_i(sys_clk_i),
  .rst_i(rst_i),
  .otg_pin_i(otg_pin_i),
  .bat_above_low_i(bat_above_low_i),
  .bus_below_bat_sleep_i(bus_below_bat_sleep_i),
  .in_cur_over_i(in_cur_over_i),
  .in_volt_under_i(in_volt_under_i),
  .fault_read_i(fault_read_i),
  .charge_config_o(charge_config_o),
  .switch_disable_o(switch_disable_o),
  .input_source_status_o(input_source_status_o),
  .charge_phase_o(charge_phase_o),
  .dpm_status_o(dpm_status_o),
  .boost_fault_bit_o(boost_fault_bit_o),
  .boost_on_o(boost_on_o),
  .reduce_charge_o(reduce_charge_o),
  .battery_path_switch_o(battery_path_switch_o),
  .charging_o(charging_o),
  .stat_pin_o(stat_pin_o),
  .stat_pin_oe_o(stat_pin_oe_o),
  .int_n_o(int_n_o)
);

// ### verif/cbp_host.sv
`timescale 1ns/1ps
// ------------------
// Host model: field writes, fault reads, interrupt count
// ------------------
module cbp_host (
  input wire sys_clk_i,
  input wire int_n_o,
  output reg [1:0] charge_config_i = 2'h0,
  output reg boost_ilim_sel_i = 1'h0,
  output reg [2:0] min_sys_i = 3'h0,
  output reg batlow_sel_i = 1'h0,
  output reg rechg_sel_i = 1'h0,
  output reg switch_disable_i = 1'h0,
  output wire charge_config_we_i,
  output wire boost_ilim_we_i,
  output wire min_sys_we_i,
  output wire cfg_bits_we_i,
  output wire switch_disable_we_i,
  output wire fault_read_i
);
  reg [5:0] we = 6'h00;
  integer ints = 0;
  assign {fault_read_i, switch_disable_we_i, cfg_bits_we_i} = we[5:3];
  assign {min_sys_we_i, boost_ilim_we_i, charge_config_we_i} = we[2:0];
  // Falling edges only, so a held low level counts once
  always @(negedge int_n_o) ints = ints + 1;
  // one-cycle strobe
  // All fields carry the data; only the strobed one is taken
  task wr(input [2:0] k, input [2:0] v);
    begin
      @(posedge sys_clk_i);
      charge_config_i <= v[1:0];
      boost_ilim_sel_i <= v[0];
      min_sys_i <= v;
      batlow_sel_i <= v[1];
      rechg_sel_i <= v[0];
      switch_disable_i <= v[0];
      we <= 6'h01 << k;
      @(posedge sys_clk_i);
      we <= 6'h00;
    end
  endtask
endmodule

// ### verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  reg sys_clk_i = 1'h0, rst_i = 1'h1, otg_pin_i = 1'h0, charge_en_n_i = 1'h1;
  reg bat_above_low_i = 1'h0, bus_below_bat_sleep_i = 1'h1, boost_fault_i = 1'h0;
  reg converter_up_i = 1'h0, thermistor_fault_i = 1'h0, timer_fault_i = 1'h0;
  reg sys_at_min_i = 1'h0, in_cur_over_i = 1'h0, in_volt_under_i = 1'h0;
  reg sys_below_bat_i = 1'h0, bat_below_depl_i = 1'h0, ichg_below_term_i = 1'h0;
  reg bat_above_rechg_i = 1'h0, bat_above_precharge_i = 1'h0;
  wire [1:0] charge_config_i, charge_config_o, input_source_status_o, charge_phase_o;
  wire [2:0] min_sys_i, min_sys_o;
  wire charge_config_we_i, boost_ilim_sel_i, boost_ilim_we_i, min_sys_we_i, batlow_sel_i;
  wire rechg_sel_i, cfg_bits_we_i, switch_disable_i, switch_disable_we_i, fault_read_i;
  wire boost_ilim_sel_o, batlow_sel_o, rechg_sel_o, switch_disable_o, dpm_status_o;
  wire min_sys_status_o, boost_fault_bit_o, boost_on_o, boost_ilim_high_o, reduce_charge_o;
  wire battery_path_switch_o, charging_o, stat_pin_o, stat_pin_oe_o, int_n_o;
  // Open-drain status line with its pull-up
  wire stat_line = stat_pin_oe_o ? stat_pin_o : 1'h1;
  integer bad_count = 0;
  integer cmp_count = 0;
  always #2 sys_clk_i = ~sys_clk_i;
  cbp_host host (.*);
  cbp_ctrl #(.BOOST_DLY_CYC(20), .INT_CYC(16), .BLINK_HALF_CYC(10)) dut (.*);
  task chk(input [31:0] s, input [31:0] e, input [8*6:1] nm);
    begin
      cmp_count = cmp_count + 1;
      if (s !== e) begin
        bad_count = bad_count + 1;
        $display("unexpected %0s: expected %0h seen %0h", nm, e, s);
      end
    end
  endtask
  task complete_run;
    begin
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  task cyc(input integer n);
    begin
      repeat (n) @(posedge sys_clk_i);
      #1;
    end
  endtask
  task pulse;
    integer n;
    begin
      n = 0;
      repeat (8) if (int_n_o !== 1'h0) cyc(1);
      while (int_n_o === 1'h0 && n < 40) begin
        n = n + 1;
        cyc(1);
      end
      chk(n, 16, "intw");
    end
  endtask
  task t_boost;
    begin
      host.wr(3'h0, 3'h2);
      otg_pin_i <= 1'h1;
      cyc(40);
      chk(boost_on_o, 1'h0, "lowbat");
      @(posedge sys_clk_i);
      bat_above_low_i <= 1'h1;
      cyc(15);
      chk(boost_on_o, 1'h0, "early");
      repeat (12) if (boost_on_o !== 1'h1) cyc(1);
      chk(input_source_status_o, 2'h3, "src");
      chk(boost_ilim_high_o, 1'h0, "ilim0");
      host.wr(3'h1, 3'h1);
      cyc(1);
      chk(boost_ilim_high_o, 1'h1, "ilim1");
      chk(boost_ilim_sel_o, 1'h1, "ilsel");
      @(posedge sys_clk_i);
      boost_fault_i <= 1'h1;
      pulse;
      chk(boost_fault_bit_o, 1'h1, "fault");
      @(posedge sys_clk_i);
      boost_fault_i <= 1'h0;
      otg_pin_i <= 1'h0;
      host.wr(3'h5, 3'h0);
      cyc(6);
      chk(boost_fault_bit_o, 1'h0, "fclr");
      chk(boost_on_o, 1'h0, "otgoff");
    end
  endtask
  task t_power;
    begin
      @(posedge sys_clk_i);
      sys_at_min_i <= 1'h1;
      in_volt_under_i <= 1'h1;
      sys_below_bat_i <= 1'h1;
      cyc(6);
      chk({min_sys_status_o, dpm_status_o, reduce_charge_o}, 3'h7, "dpmv");
      chk(battery_path_switch_o, 1'h1, "suppl");
      @(posedge sys_clk_i);
      in_volt_under_i <= 1'h0;
      in_cur_over_i <= 1'h1;
      bat_below_depl_i <= 1'h1;
      cyc(6);
      chk(dpm_status_o, 1'h1, "dpmi");
      chk(battery_path_switch_o, 1'h0, "depl");
      @(posedge sys_clk_i);
      in_cur_over_i <= 1'h0;
      sys_at_min_i <= 1'h0;
      cyc(6);
      chk({min_sys_status_o, dpm_status_o}, 2'h0, "dpm0");
      host.wr(3'h3, 3'h1);
      host.wr(3'h2, 3'h6);
      cyc(1);
      chk({batlow_sel_o, rechg_sel_o, min_sys_o}, 5'h0e, "cfgw");
    end
  endtask
  task t_charge;
    integer n;
    reg s;
    begin
      @(posedge sys_clk_i);
      bat_below_depl_i <= 1'h0;
      sys_below_bat_i <= 1'h0;
      converter_up_i <= 1'h1;
      host.wr(3'h0, 3'h1);
      cyc(6);
      chk(charging_o, 1'h0, "cehigh");
      @(posedge sys_clk_i);
      charge_en_n_i <= 1'h0;
      cyc(6);
      chk({charging_o, charge_phase_o, stat_line}, 4'ha, "pre");
      @(posedge sys_clk_i);
      bat_above_precharge_i <= 1'h1;
      cyc(6);
      chk(charge_phase_o, 2'h2, "fast");
      n = host.ints;
      @(posedge sys_clk_i);
      ichg_below_term_i <= 1'h1;
      bat_above_rechg_i <= 1'h1;
      pulse;
      cyc(30);
      chk(host.ints - n, 1, "oneint");
      chk({charge_phase_o, stat_line}, 3'h7, "done");
      @(posedge sys_clk_i);
      bat_above_rechg_i <= 1'h0;
      cyc(6);
      chk(charge_phase_o, 2'h2, "rechg");
      @(posedge sys_clk_i);
      thermistor_fault_i <= 1'h1;
      cyc(6);
      chk(charge_phase_o, 2'h0, "susp");
      s = stat_pin_oe_o;
      cyc(10);
      chk(stat_pin_oe_o, !s, "blink");
      @(posedge sys_clk_i);
      thermistor_fault_i <= 1'h0;
      host.wr(3'h4, 3'h1);
      cyc(6);
      chk(battery_path_switch_o, 1'h0, "swoff");
      chk(switch_disable_o, 1'h1, "swdis");
      host.wr(3'h0, 3'h0);
      host.wr(3'h4, 3'h0);
      cyc(6);
      chk({charging_o, charge_phase_o, stat_line}, 4'h1, "cfgoff");
    end
  endtask
  initial begin
    repeat (20) @(posedge sys_clk_i);
    rst_i <= 1'h0;
    cyc(2);
    chk({charge_config_o, min_sys_o, int_n_o}, 6'h1b, "reset");
    t_boost;
    t_power;
    t_charge;
    complete_run;
  end
  // Whole sequence needs under a thousand cycles
  initial begin
    #20000;
    bad_count = bad_count + 1;
    complete_run;
  end
endmodule
